/* include/sfcp_regs.svh */
// Opcodes, status layout, reset values and timing counts of the serial flash front end.
`ifndef SFCP_REGS_SVH
`define SFCP_REGS_SVH

// ==========================================================================
// Opcode keys, with bit 3 removed: {op[7:4], op[2:0]}.
`define SFCP_KEY_LATCH_SET    7'h06
`define SFCP_KEY_LATCH_CLEAR  7'h04
`define SFCP_KEY_STATUS_READ  7'h05
`define SFCP_KEY_STATUS_WRITE 7'h01
`define SFCP_KEY_ARRAY_READ   7'h03
`define SFCP_KEY_PROGRAM      7'h02
`define SFCP_KEY_SECTOR_ERASE 7'h2A
`define SFCP_KEY_CHIP_ERASE   7'h32
`define SFCP_KEY_ID_READ      7'h0D

// ==========================================================================
// Status byte bit positions and values.
`define SFCP_ST_ARM       7
`define SFCP_ST_GUARD_HI  3
`define SFCP_ST_GUARD_LO  2
`define SFCP_ST_LATCH     1
`define SFCP_ST_BUSY      0
`define SFCP_ST_ALL_ONES  8'hFF
`define SFCP_NV_RESET     3'h0
`define SFCP_ID_FILL      8'h00

// ==========================================================================
// Self-timed cycle lengths and their counts at the system clock rate.
`define SFCP_CLK_MHZ      100
`define SFCP_TBPC_US      50
`define SFCP_TEC_MS       1000
`define SFCP_TCE_MS       4000
`define SFCP_TSR_MS       60
`define SFCP_PROG_CYC     (`SFCP_TBPC_US * `SFCP_CLK_MHZ)
`define SFCP_SE_CYC       (`SFCP_TEC_MS * 1000 * `SFCP_CLK_MHZ)
`define SFCP_CE_CYC       (`SFCP_TCE_MS * 1000 * `SFCP_CLK_MHZ)
`define SFCP_SR_CYC       (`SFCP_TSR_MS * 1000 * `SFCP_CLK_MHZ)

`endif

/* include/sfcp_pkg.sv */
// Types shared by the serial flash front end.
package sfcp_pkg;

  // ==========================================================================
  // Frame sequencer states.
  typedef enum logic [6:0]
  {
    ST_IDLE   = 7'h01,
    ST_CMD    = 7'h02,
    ST_ADDR   = 7'h04,
    ST_OUT    = 7'h08,
    ST_WDATA  = 7'h10,
    ST_ARMED  = 7'h20,
    ST_IGNORE = 7'h40
  } sfcp_state_e;

  // ==========================================================================
  // One program byte with its array address.
  typedef struct packed
  {
    logic [17:0] addr;
    logic [7:0]  data;
  } sfcp_word_s;

  // Raw link pins in one bundle.
  typedef struct packed
  {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic guard_n;
  } sfcp_pins_s;

endpackage : sfcp_pkg

/* verilog/sfcp_flash_front.sv */
// Serial flash command front end with its program data FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "sfcp_regs.svh"

// ==========================================================================
// FIFO with a registered output stage.
module sfcp_fifo
#(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Control
  input  wire logic             flush,
  input  wire logic             drain_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sfcp_fifo: DEPTH must be a power of two >= 2");
  end

  wire stage_free = ~out_valid | out_ready;
  wire push       = in_valid & in_ready & ~flush;
  wire pop        = drain_en & stage_free & (count_r != '0) & ~flush;

  assign in_ready = (count_r != (AW + 1)'(DEPTH));

  always_ff @(posedge sys_clk)
  begin
    if (push) mem[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (flush)
    begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
      if (pop)
      begin
        out_valid <= 1'b1;
        out_data  <= mem[rd_ptr_r];
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : sfcp_fifo

// ==========================================================================
// Device-side command front end.
module sfcp_flash_front
  import sfcp_pkg::*;
#(
  parameter int         FIFO_DEPTH  = 8,
  parameter int         PROG_CYCLES = `SFCP_PROG_CYC,
  parameter int         SE_CYCLES   = `SFCP_SE_CYC,
  parameter int         CE_CYCLES   = `SFCP_CE_CYC,
  parameter int         SR_CYCLES   = `SFCP_SR_CYC,
  parameter logic [7:0] MFR_CODE    = 8'hA5,  // Arbitrary value.
  parameter logic [7:0] DEV_CODE    = 8'h5A   // Arbitrary value.
)
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  // Link pins
  input  wire sfcp_pkg::sfcp_pins_s pins,
  output logic                     so_out,
  output logic                     so_oe,
  // Array read port
  output logic                     rd_req,
  output logic [17:0]              rd_addr,
  input  wire logic [7:0]          rd_data,
  // Array program port
  output logic                     prog_valid,
  input  wire logic                prog_ready,
  output sfcp_pkg::sfcp_word_s     prog_word,
  // Array erase port
  output logic                     erase_req,
  output logic [3:0]               erase_mask,
  // Status view
  output logic [7:0]               status
);
  import sfcp_pkg::*;

  initial
  begin
    if (PROG_CYCLES < 1 || SE_CYCLES < 1 || CE_CYCLES < 1 || SR_CYCLES < 1)
      $error("sfcp_flash_front: cycle counts must be at least one");
  end

  // ==========================================================================
  // Helper functions.
  function automatic logic [6:0] op_key(input logic [7:0] op);
    op_key = {op[7:4], op[2:0]};
  endfunction : op_key

  function automatic logic sector_locked(input logic [1:0] guard, input logic [1:0] sector);
    sector_locked = (guard == 2'h3) | ((guard == 2'h2) & sector[1]) |
                    ((guard == 2'h1) & (sector == 2'h3));
  endfunction : sector_locked

  // ==========================================================================
  // Pin synchronisers and edge detection.
  sfcp_pins_s  meta_r;
  sfcp_pins_s  sync_r;
  logic        sck_d_r;
  logic        cs_d_r;
  logic        guard_d_r;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r    <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, guard_n: 1'b1};
      sync_r    <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, guard_n: 1'b1};
      sck_d_r   <= 1'b0;
      cs_d_r    <= 1'b1;
      guard_d_r <= 1'b1;
    end
    else
    begin
      meta_r    <= pins;
      sync_r    <= meta_r;
      sck_d_r   <= sync_r.sck;
      cs_d_r    <= sync_r.cs_n;
      guard_d_r <= sync_r.guard_n;
    end
  end

  wire active   = ~sync_r.cs_n & sync_r.hold_n;
  wire sck_rise = active & sync_r.sck & ~sck_d_r;
  wire sck_fall = active & ~sync_r.sck & sck_d_r;
  wire cs_fall  = ~sync_r.cs_n & cs_d_r;
  wire cs_rise  = sync_r.cs_n & ~cs_d_r;
  wire guard_fall = guard_d_r & ~sync_r.guard_n;

  // ==========================================================================
  // Registers.
  sfcp_state_e state_r;
  logic [6:0]  cmd_r;
  logic [5:0]  bit_cnt_r;
  logic [6:0]  in_sr_r;
  logic [17:0] addr_r;
  logic [8:0]  byte_cnt_r;
  logic [7:0]  tx_r;
  logic        rd_pend_r;
  logic        latch_r;
  logic [2:0]  nv_r;
  logic [2:0]  nv_new_r;
  logic        pend_nv_r;
  logic        guard_abort_r;
  logic        release_r;
  logic [31:0] busy_cnt_r;

  // ==========================================================================
  // Decode and selection.
  wire [7:0] rx_byte   = {in_sr_r, sync_r.si};
  wire [6:0] rx_key    = op_key(rx_byte);
  wire       byte_end  = (bit_cnt_r[2:0] == 3'h7);
  wire       cmd_done  = sck_rise & byte_end & (state_r == ST_CMD);
  wire       addr_done = sck_rise & (state_r == ST_ADDR) & (bit_cnt_r == 6'h1F);
  wire       busy      = (busy_cnt_r != 32'h0000_0000);
  wire       busy_end  = (busy_cnt_r == 32'h0000_0001);
  wire       hw_prot   = ~sync_r.guard_n & nv_r[2];
  wire [1:0] guard     = nv_r[1:0];
  wire [7:0] status_byte = busy ? `SFCP_ST_ALL_ONES :
                         {nv_r[2], 3'h0, nv_r[1:0], latch_r, 1'b0};
  wire [3:0] free_mask = {~sector_locked(guard, 2'h3), ~sector_locked(guard, 2'h2),
                          ~sector_locked(guard, 2'h1), ~sector_locked(guard, 2'h0)};
  wire       addr_lock = sector_locked(guard, addr_r[17:16]);
  wire       is_prog   = (cmd_r == `SFCP_KEY_PROGRAM);
  wire       is_sr     = (cmd_r == `SFCP_KEY_STATUS_WRITE);
  wire       is_se     = (cmd_r == `SFCP_KEY_SECTOR_ERASE);
  wire       is_read   = (cmd_r == `SFCP_KEY_ARRAY_READ);
  wire       is_id     = (cmd_r == `SFCP_KEY_ID_READ);
  wire       in_wdata  = (state_r == ST_WDATA);
  wire       in_armed  = (state_r == ST_ARMED);
  wire       go_prog   = cs_rise & in_wdata & is_prog & (byte_cnt_r != 9'h000) & ~addr_lock;
  wire       go_sr     = cs_rise & in_wdata & is_sr & (byte_cnt_r != 9'h000) &
                         ~hw_prot & ~guard_abort_r;
  wire       go_se     = cs_rise & in_armed & is_se & ~addr_lock;
  wire       go_ce     = cs_rise & in_armed & ~is_se & (free_mask != 4'h0);
  wire       push      = sck_rise & byte_end & in_wdata & is_prog;
  wire       flush     = cs_rise & in_wdata & is_prog & ~go_prog;
  wire [31:0] prog_len = 32'(byte_cnt_r) * 32'(PROG_CYCLES);

  // ==========================================================================
  // Frame sequencer.
  sfcp_state_e cmd_state;

  always_comb
  begin
    cmd_state = ST_IGNORE;
    if (!busy || rx_key == `SFCP_KEY_STATUS_READ)
    begin
      case (rx_key)
        `SFCP_KEY_STATUS_READ:  cmd_state = ST_OUT;
        `SFCP_KEY_ID_READ:      cmd_state = ST_OUT;
        `SFCP_KEY_ARRAY_READ:   cmd_state = ST_ADDR;
        `SFCP_KEY_STATUS_WRITE: cmd_state = latch_r ? ST_WDATA : ST_IGNORE;
        `SFCP_KEY_PROGRAM:      cmd_state = latch_r ? ST_ADDR : ST_IGNORE;
        `SFCP_KEY_SECTOR_ERASE: cmd_state = latch_r ? ST_ADDR : ST_IGNORE;
        `SFCP_KEY_CHIP_ERASE:   cmd_state = latch_r ? ST_ARMED : ST_IGNORE;
        default:                cmd_state = ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r    <= ST_IDLE;
      cmd_r      <= 7'h00;
      bit_cnt_r  <= 6'h00;
      in_sr_r    <= 7'h00;
      addr_r     <= 18'h0_0000;
      byte_cnt_r <= 9'h000;
    end
    else if (sync_r.cs_n)
    begin
      state_r <= ST_IDLE;
    end
    else if (cs_fall)
    begin
      state_r    <= ST_CMD;
      bit_cnt_r  <= 6'h00;
      byte_cnt_r <= 9'h000;
    end
    else if (sck_rise && state_r != ST_IGNORE && state_r != ST_IDLE)
    begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
      in_sr_r   <= rx_byte[6:0];
      if (cmd_done)
      begin
        cmd_r   <= rx_key;
        state_r <= cmd_state;
      end
      if (state_r == ST_ADDR)
      begin
        addr_r <= {addr_r[16:0], sync_r.si};
      end
      if (addr_done)
      begin
        state_r <= is_read ? ST_OUT : (is_prog ? ST_WDATA : ST_ARMED);
      end
      if (state_r == ST_OUT && byte_end)
      begin
        byte_cnt_r <= (byte_cnt_r == 9'h1FF) ? byte_cnt_r : byte_cnt_r + 9'h001;
        if (is_read) addr_r <= addr_r + 18'h0_0001;
      end
      if (push)
      begin
        addr_r[7:0] <= addr_r[7:0] + 8'h01;
        byte_cnt_r  <= (byte_cnt_r == 9'h100) ? byte_cnt_r : byte_cnt_r + 9'h001;
      end
      if (in_wdata && is_sr && byte_end && byte_cnt_r == 9'h000)
      begin
        byte_cnt_r <= 9'h001;
      end
    end
  end

  // ==========================================================================
  // Serial output path.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_r      <= 8'h00;
      so_out    <= 1'b0;
      so_oe     <= 1'b0;
      rd_req    <= 1'b0;
      rd_addr   <= 18'h0_0000;
      rd_pend_r <= 1'b0;
    end
    else
    begin
      so_oe     <= active & (state_r == ST_OUT);
      rd_req    <= 1'b0;
      rd_pend_r <= rd_req;
      if (rd_pend_r) tx_r <= rd_data;
      if (cmd_done && cmd_state == ST_OUT)
      begin
        tx_r <= is_id_key(rx_key) ? MFR_CODE : status_byte;
      end
      else if (addr_done && is_read)
      begin
        rd_req  <= 1'b1;
        rd_addr <= {addr_r[16:0], sync_r.si};
      end
      else if (sck_rise && byte_end && state_r == ST_OUT)
      begin
        if (is_read)
        begin
          rd_req  <= 1'b1;
          rd_addr <= addr_r + 18'h0_0001;
        end
        else if (is_id)
          tx_r <= (byte_cnt_r == 9'h000) ? DEV_CODE : `SFCP_ID_FILL;
        else
          tx_r <= status_byte;
      end
      else if (sck_fall && state_r == ST_OUT)
      begin
        so_out <= tx_r[7];
        tx_r   <= {tx_r[6:0], 1'b0};
      end
    end
  end

  function automatic logic is_id_key(input logic [6:0] key);
    is_id_key = (key == `SFCP_KEY_ID_READ);
  endfunction : is_id_key

  // ==========================================================================
  // Write latch, protection bits and self-timed cycles.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_r       <= 1'b0;
      nv_r          <= `SFCP_NV_RESET;
      nv_new_r      <= `SFCP_NV_RESET;
      pend_nv_r     <= 1'b0;
      guard_abort_r <= 1'b0;
      release_r     <= 1'b0;
      busy_cnt_r    <= 32'h0000_0000;
      erase_req     <= 1'b0;
      erase_mask    <= 4'h0;
      status        <= 8'h00;
    end
    else
    begin
      erase_req <= 1'b0;
      status    <= status_byte;
      if (~sync_r.cs_n & guard_fall)
        guard_abort_r <= 1'b1;
      else if (cs_fall)
        guard_abort_r <= 1'b0;
      if (cmd_done && !busy && rx_key == `SFCP_KEY_LATCH_SET)
        latch_r <= 1'b1;
      if (cmd_done && !busy && rx_key == `SFCP_KEY_LATCH_CLEAR)
        latch_r <= 1'b0;
      if (in_wdata && is_sr && sck_rise && byte_end && byte_cnt_r == 9'h000)
        nv_new_r <= {rx_byte[`SFCP_ST_ARM], rx_byte[`SFCP_ST_GUARD_HI],
                     rx_byte[`SFCP_ST_GUARD_LO]};
      if (busy)
        busy_cnt_r <= busy_cnt_r - 32'h0000_0001;
      if (busy_end)
      begin
        latch_r   <= 1'b0;
        release_r <= 1'b0;
        pend_nv_r <= 1'b0;
        if (pend_nv_r) nv_r <= nv_new_r;
      end
      if (go_prog)
      begin
        release_r  <= 1'b1;
        busy_cnt_r <= prog_len;
      end
      if (go_sr)
      begin
        pend_nv_r  <= 1'b1;
        busy_cnt_r <= 32'(SR_CYCLES);
      end
      if (go_se)
      begin
        erase_req  <= 1'b1;
        erase_mask <= 4'h1 << addr_r[17:16];
        busy_cnt_r <= 32'(SE_CYCLES);
      end
      if (go_ce)
      begin
        erase_req  <= 1'b1;
        erase_mask <= free_mask;
        busy_cnt_r <= 32'(CE_CYCLES);
      end
    end
  end

  // ==========================================================================
  // Program data buffer toward the array.
  sfcp_word_s push_word;
  logic [25:0] pop_word;

  assign push_word = '{addr: addr_r, data: rx_byte};
  assign prog_word = sfcp_word_s'(pop_word);

  sfcp_fifo
  #(
    .WIDTH (26),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .flush     (flush),
    .drain_en  (release_r),
    .in_valid  (push),
    .in_ready  (),
    .in_data   (push_word),
    .out_valid (prog_valid),
    .out_ready (prog_ready),
    .out_data  (pop_word)
  );
endmodule : sfcp_flash_front

`default_nettype wire

/* tb/sfcp_spi_master.sv */
// Link master model that drives the serial pins in mode 0.
`timescale 1ns/100ps
`default_nettype none
module sfcp_spi_master
(
  // Alignment clock
  input  wire logic sys_clk,
  // Link pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n,
  input  wire logic so_out,
  input  wire logic so_oe
);
  int   hold_bit = 99;
  logic oe_seen;
  logic so_line;
  assign so_line = so_oe ? so_out : 1'bz;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  always @(posedge so_oe) oe_seen = 1'b1;
  // ==========================================================================
  // One frame of n bytes, first byte at the top of tx.
  task xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    @(posedge sys_clk);
    #1 cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++)
    begin
      si = tx[63 - i];
      #80 sck = 1'b1;
      rx = {rx[62:0], so_line};
      #80 sck = 1'b0;
      if (i == hold_bit)
      begin
        #40 hold_n = 1'b0;
        repeat (4) #80 {sck, si} = {~sck, ~si};
        #40 hold_n = 1'b1;
      end
    end
    #80 cs_n = 1'b1;
    si = ~si;
    #80;
  endtask : xfer
endmodule : sfcp_spi_master
`default_nettype wire

/* tb/sfcp_flash_front_checker.sv */
// Concurrent checks on the ports of the serial flash front end.
`timescale 1ns/100ps
`default_nettype none
module sfcp_flash_front_checker
  import sfcp_pkg::*;
(
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  // Watched ports
  input wire sfcp_pkg::sfcp_pins_s pins,
  input wire logic                 so_out,
  input wire logic                 so_oe,
  input wire logic                 rd_req,
  input wire logic [17:0]          rd_addr,
  input wire logic [7:0]           rd_data,
  input wire logic                 prog_valid,
  input wire logic                 prog_ready,
  input wire sfcp_pkg::sfcp_word_s prog_word,
  input wire logic                 erase_req,
  input wire logic [3:0]           erase_mask,
  input wire logic [7:0]           status
);
  logic [1:0]  guard_r;
  logic [17:0] last_a_r;
  logic        have_r;
  logic [3:0]  lock_w;
  assign lock_w = guard_r[1] ? (guard_r[0] ? 4'hF : 4'hC) : (guard_r[0] ? 4'h8 : 4'h0);
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      guard_r  <= 2'h0;
      last_a_r <= 18'h0;
      have_r   <= 1'b0;
    end
    else
    begin
      if (!status[0])
        guard_r <= status[3:2];
      if (rd_req)
        last_a_r <= rd_addr;
      have_r <= rd_req | (have_r & ~pins.cs_n);
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  property p_desel;
    pins.cs_n [*6] |-> !so_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("output on while deselected");
  property p_hold;
    !pins.hold_n [*6] |-> !so_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("output on during hold");
  property p_busy;
    status[0] |-> status == 8'hFF;
  endproperty
  a_busy: assert property (p_busy) else $error("busy status not all ones");
  property p_idle;
    !status[0] |-> status[6:4] == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle status bits 4 to 6 set");
  property p_lock;
    erase_req |-> (erase_mask & lock_w) == 4'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("locked sector erased");
  property p_erbusy;
    erase_req |-> ##[1:4] status[0];
  endproperty
  a_erbusy: assert property (p_erbusy) else $error("erase without busy");
  property p_endclr;
    $fell(status[0]) |-> !status[1];
  endproperty
  a_endclr: assert property (p_endclr) else $error("latch kept after cycle");
  property p_rdinc;
    rd_req && have_r |-> rd_addr == 18'(last_a_r + 18'h1);
  endproperty
  a_rdinc: assert property (p_rdinc) else $error("read address step wrong");
  property p_prog;
    prog_valid |-> pins.cs_n;
  endproperty
  a_prog: assert property (p_prog) else $error("program word inside frame");
  c_erase: cover property (erase_req);
  c_prog: cover property (prog_valid && prog_ready);
  c_out: cover property ($rose(so_oe));
endmodule : sfcp_flash_front_checker
bind sfcp_flash_front sfcp_flash_front_checker u_chk
(
  .sys_clk(sys_clk), .reset_n(reset_n), .pins(pins), .so_out(so_out),
  .so_oe(so_oe), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
  .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_word(prog_word),
  .erase_req(erase_req), .erase_mask(erase_mask), .status(status)
);
`default_nettype wire

/* tb/sfcp_flash_front_test.sv */
// Self-checking bench for the serial flash front end.
`timescale 1ns/100ps
`default_nettype none
module sfcp_flash_front_test;
  import sfcp_pkg::*;
  logic        sys_clk, reset_n, guard_n, prog_ready;
  logic        cs_n, sck, si, hold_n;
  logic        so_out, so_oe, rd_req, prog_valid, erase_req;
  logic [17:0] rd_addr, a;
  logic [7:0]  rd_data, status;
  logic [7:0]  d [3];
  logic [3:0]  erase_mask, er_mask;
  logic [16:0] rnd = 17'h1_6456;
  logic [63:0] rx;
  sfcp_pins_s  pins;
  sfcp_word_s  prog_word;
  sfcp_word_s  pq [$];
  int          bad_count, num_checks, er_cnt, cyc;
  // ==========================================================================
  // Helpers.
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  function automatic logic [7:0] ard(input logic [17:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3C;
  endfunction : ard
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex)
    begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask : chk
  task x(input logic [63:0] tx, input int n);
    m.xfer(tx << (64 - 8 * n), n, rx);
  endtask : x
  task sr(input logic [7:0] ex);
    x(64'h0500, 2);
    chk("status byte", ex, rx[7:0]);
  endtask : sr
  task widle;
    for (int i = 0; i < 3000 && status[0] !== 1'b0; i++)
      @(posedge sys_clk);
    #1;
    chk("busy end", 1'b0, status[0]);
  endtask : widle
  // ==========================================================================
  // Design, link master and far-side models.
  assign pins = {cs_n, sck, si, hold_n, guard_n};
  assign rd_data = ard(rd_addr);
  sfcp_spi_master m (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));
  sfcp_flash_front #(.PROG_CYCLES(30), .SE_CYCLES(100), .CE_CYCLES(100),
    .SR_CYCLES(600)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .pins(pins),
    .so_out(so_out), .so_oe(so_oe), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_word(prog_word), .erase_req(erase_req), .erase_mask(erase_mask),
    .status(status));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (prog_valid && prog_ready)
      pq.push_back(prog_word);
    if (erase_req)
    begin
      er_cnt++;
      er_mask = erase_mask;
    end
    cyc++;
    #1 rnd = lfsr(rnd);
    prog_ready = rnd[0];
    if (cyc == 30000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Main sequence.
  initial
  begin
    reset_n = 1'b0;
    guard_n = 1'b1;
    prog_ready = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("reset status", 8'h00, status);
    x(64'h0D00, 2);
    chk("status alias", 8'h00, rx[7:0]);
    x(64'h0E, 1);
    sr(8'h02);
    x(64'h0C, 1);
    chk("latch clear", 8'h00, status);
    m.hold_bit = 11;
    x(64'h1D_0000, 3);
    m.hold_bit = 99;
    chk("id bytes", 16'hA55A, rx[15:0]);
    x(64'hFF_0000, 3);
    chk("invalid op drive", 1'b0, m.oe_seen);
    x(64'h018C, 2);
    chk("unlatched write", 8'h00, status);
    x(64'h0BFF_FFFF_0000, 6);
    chk("read wrap", {ard(18'h3_FFFF), ard(18'h0)}, rx[15:0]);
    a = {2'h0, rnd[7:0], 8'hFE};
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      d[k] = rnd[10:3];
    end
    x(64'h06, 1);
    x({8'h0A, 6'h3F, a, d[0], d[1], d[2]}, 7);
    widle;
    chk("word count", 3, pq.size());
    for (int k = 0; k < 3; k++)
      chk("prog word", {a[17:8], 8'(a[7:0] + k), d[k]}, pq[k]);
    chk("latch after prog", 1'b0, status[1]);
    x(64'h06, 1);
    x(64'h0904, 2);
    sr(8'hFF);
    x(64'h06, 1);
    widle;
    chk("status write", 8'h04, status);
    x(64'h5201_0000, 4);
    x(64'h06, 1);
    x(64'h5203_0000, 4);
    chk("locked erase", 0, er_cnt);
    sr(8'h06);
    x(64'h5A01_0000, 4);
    widle;
    chk("sector mask", 4'h2, er_mask);
    chk("latch after erase", 8'h04, status);
    x(64'h06, 1);
    x(64'h6A, 1);
    widle;
    chk("chip mask", 4'h7, er_mask);
    chk("erase count", 2, er_cnt);
    x(64'h06, 1);
    x(64'h0980, 2);
    widle;
    chk("arm set", 8'h80, status);
    guard_n = 1'b0;
    x(64'h06, 1);
    x(64'h010C, 2);
    widle;
    chk("pin guarded", 6'h20, status[7:2]);
    guard_n = 1'b1;
    x(64'h06, 1);
    fork
      x(64'h010C, 2);
      begin
        #700 guard_n = 1'b0;
        #300 guard_n = 1'b1;
      end
    join
    widle;
    chk("pin abort", 6'h20, status[7:2]);
    x(64'h06, 1);
    x(64'h0100, 2);
    widle;
    chk("pin high write", 8'h00, status);
    wrap_up();
  end
endmodule : sfcp_flash_front_test
`default_nettype wire
